/* design/ocs_clock_source.sv */
`timescale 1ns/10ps
// Behaviour
// R1: secondary pin: crystal inverts input pin; ext clock gpio; internal/RC enable picks gpio or quad clock.
// R2: select field decodes 00 internal, 01 ext clock, 10 RC, 11 crystal.
// R3: reset selects the internal oscillator as bus clock source.
// R4: internal frequency field picks 4.0, 8.0 or 12.8 MHz; 11 reserved.
// R5: wait mode leaves the oscillator and both bus clocks running.
// R6: crystal range field enables the matching amplifier; 11 reserved.
// R7: external request bit is read/write, reset clear, starts the switch.
// R8: external request is ignored in monitor mode with internal oscillator bypassed.
// R9: engaged flag reads 1 while external source drives clock, else 0.
// R10: 8-bit trim changes period by about 0.2 % per step.
// R11: trim acts relative to the selected internal frequency.
// R12: software copies the factory trim into the trim register; no auto load.
// R13: after request wait two external rising edges, switch, set engaged, stop internal.
// R14: clearing select and request returns the bus clock to the internal oscillator.
// R15: double bus clock is the quad bus clock divided by two.
// R16: external clock mode forces the clock output enable bit clear.
// R17: source switching is glitch free, no short clock pulse.
module ocs_clock_source
    import ocs_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // register bus
    input  wire ocs_wb_req_t wb_i,
    output ocs_wb_rsp_t      wb_o,
    // pins and chip strap
    input  wire logic        clock_input_pin_i,
    input  wire logic        monitor_bypass_i,
    input  wire logic        gpio_out_i,
    input  wire logic        gpio_oe_i,
    output ocs_pin_t         secondary_clock_pin_o,
    // clocks and oscillator controls
    output logic             quad_bus_clock_o,
    output logic             double_bus_clock_o,
    output logic             internal_osc_run_o,
    output logic             clock_input_enable_o,
    output logic [2:0]       crystal_amp_enable_o
);

    // half period of the modelled internal oscillator for the chosen frequency and trim
    function automatic logic [7:0] osc_half(input logic [1:0] ifs, input logic [7:0] trim);
        logic [7:0]         base;
        logic signed [8:0]  step;
        logic signed [17:0] prod;
        // the reserved frequency code runs at the reset frequency
        base = HALF_4M0;
        if (ifs == IFS_8M0)
            base = HALF_8M0;
        else if (ifs == IFS_12M8)
            base = HALF_12M8;
        // trim is offset binary around the centre code; a larger code gives a longer period
        step = $signed({1'b0, trim}) - $signed({1'b0, TRIM_CENTRE});
        prod = $signed({10'h000, base}) * 18'(step);
        osc_half = base + 8'(prod >>> TRIM_SHIFT);
    endfunction : osc_half

    // registers and state
    logic [1:0] sel_q;
    logic [1:0] ifs_q;
    logic [1:0] xr_q;
    logic       req_q;
    logic       oen_q;
    logic [7:0] trim_q;
    ocs_state_t state_q;
    ocs_state_t state_d;
    logic       src_ext_q;
    logic       engaged_q;
    logic [1:0] edges_q;
    logic       int_run_q;
    logic [7:0] int_cnt_q;
    logic       int_lvl_q;
    logic       quad_q;
    logic       dbl_q;
    logic       ack_q;
    logic [31:0] rdat_q;
    ocs_pin_t   pin_q;
    logic       mon_meta_q;
    logic       mon_q;
    logic       ext_meta_q;
    logic       ext_lvl_q;
    logic       ext_prev_q;

    // bus decode
    // only byte lane 0 carries register data, so sel[0] alone qualifies a write
    wire        bus_req     = wb_i.cyc & wb_i.stb & ~ack_q;
    wire        bus_wr      = bus_req & wb_i.we & wb_i.sel[0];
    wire        hit_control = (wb_i.adr == ADDR_CONTROL);
    wire        hit_trim    = (wb_i.adr == ADDR_TRIM);
    wire        hit_pincfg  = (wb_i.adr == ADDR_PINCFG);
    wire [7:0]  wbyte       = wb_i.dat[7:0];
    wire [1:0]  sel_wr      = wbyte[SEL_HI:SEL_LO];
    wire [7:0]  control_rd  = {sel_q, ifs_q, xr_q, req_q, engaged_q};  // [R9]
    wire [7:0]  rd_byte     = hit_control ? control_rd :
                              hit_trim    ? trim_q :
                              hit_pincfg  ? {7'h00, oen_q} : 8'h00;

    // switching conditions; monitor bypass masks the request
    wire        req_eff     = req_q & ~mon_q;  // [R8]
    wire        ext_rise    = ext_lvl_q & ~ext_prev_q;
    wire        int_done    = (int_cnt_q + 8'h01) >= osc_half(ifs_q, trim_q);  // [R4] [R10] [R11]
    wire        src_lvl     = src_ext_q ? ext_lvl_q : int_lvl_q;
    wire        quad_rise   = src_lvl & ~quad_q;
    // a switch only lands while the bus clock and both sources are low; quad_q
    // still takes the old source at the switching edge, so that one must be low too
    // engaging waits for a falling external edge, so the low phase that follows is
    // a full external half period and never a sliver of one
    wire        ext_fall    = ~ext_lvl_q & ext_prev_q;
    wire        ext_safe    = ~quad_q & ~int_lvl_q & ext_fall;  // [R17]
    // returning waits for a low external level; the restarted internal oscillator
    // begins with its low half, so the low phase is long on both sides
    // limitation: an external clock that stops high holds the return back for good
    wire        int_safe    = ~quad_q & ~ext_lvl_q & ~int_lvl_q & int_run_q;  // [R17]

    // secondary pin selection
    // in crystal mode the inverted synchronised pin stands in for the amplifier output
    wire        mode_xtal   = (sel_q == SEL_CRYSTAL);  // [R2]
    wire        mode_extclk = (sel_q == SEL_EXT_CLK);  // [R2]
    ocs_pin_t   pin_d;
    assign pin_d.out = mode_xtal   ? ~ext_lvl_q :
                       mode_extclk ? gpio_out_i :
                       oen_q       ? quad_q : gpio_out_i;  // [R1]
    assign pin_d.oe  = mode_xtal   ? 1'b1 :
                       mode_extclk ? gpio_oe_i :
                       oen_q       ? 1'b1 : gpio_oe_i;  // [R1]

    // amplifier enable for the crystal range
    // the reserved range code enables no amplifier rather than guess one
    wire [2:0]  amp_d = ~mode_xtal      ? AMP_OFF :
                        (xr_q == XR_HIGH) ? AMP_HIGH :
                        (xr_q == XR_MID)  ? AMP_MID :
                        (xr_q == XR_LOW)  ? AMP_LOW : AMP_OFF;  // [R6]

    // sequencer events shared by the next-state logic and the flag logic
    wire        edge_last   = ext_rise && (edges_q == EDGE_COUNT - 2'h1);  // [R13]
    wire        engage_now  = (state_q == ST_SWITCH) && (state_d == ST_EXTERNAL);  // [R13]
    wire        release_now = (state_q == ST_BACK) && (state_d == ST_INTERNAL);  // [R14]

    // engagement sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            // a request masked by the bypass strap never leaves here
            ST_INTERNAL: if (req_eff) state_d = ST_EDGES;  // [R7]
            // count external rising edges; a dropped request aborts the attempt
            ST_EDGES:
            begin
                if (!req_eff)
                    state_d = ST_INTERNAL;
                else if (edge_last)
                    state_d = ST_SWITCH;  // [R13]
            end
            // wait for a safe moment to hand the bus clock to the pin
            ST_SWITCH:
            begin
                if (!req_eff)
                    state_d = ST_INTERNAL;
                else if (ext_safe)
                    state_d = ST_EXTERNAL;  // [R13]
            end
            // a cleared request starts the return
            ST_EXTERNAL: if (!req_eff) state_d = ST_BACK;  // [R14]
            // internal oscillator restarted; hand back once every clock is low
            ST_BACK:     if (int_safe) state_d = ST_INTERNAL;  // [R14]
            // an unused code falls back to the internal source
            default:     state_d = ST_INTERNAL;
        endcase
    end

    // synchronisers for the pin and the strap
    // logic reads only the second stage; ext_prev_q is a plain delay for edge detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_meta_q <= 1'b0;
            ext_lvl_q  <= 1'b0;
            ext_prev_q <= 1'b0;
            mon_meta_q <= 1'b0;
            mon_q      <= 1'b0;
        end
        else if (ce_i)
        begin
            ext_meta_q <= clock_input_pin_i;
            ext_lvl_q  <= ext_meta_q;
            ext_prev_q <= ext_lvl_q;
            mon_meta_q <= monitor_bypass_i;
            mon_q      <= mon_meta_q;
        end
    end

    // register writes; hardware loads trim only at reset, with TRIM_RESET
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {sel_q, ifs_q, xr_q, req_q} <= CONTROL_RESET[SEL_HI:REQ_BIT];  // [R3] [R7]
            trim_q <= TRIM_RESET;  // [R12]
            oen_q  <= 1'b0;
        end
        else if (ce_i)
        begin
            // the engaged bit in the write data is read-only and dropped
            if (bus_wr && hit_control)
            begin
                sel_q <= sel_wr;
                ifs_q <= wbyte[IFS_HI:IFS_LO];
                xr_q  <= wbyte[XR_HI:XR_LO];
                req_q <= wbyte[REQ_BIT];  // [R7]
            end
            if (bus_wr && hit_trim)
                trim_q <= wbyte;  // [R10]
            // the enable cannot hold while the pin belongs to an external clock
            if (mode_extclk || (bus_wr && hit_control && sel_wr == SEL_EXT_CLK))
                oen_q <= 1'b0;  // [R16]
            else if (bus_wr && hit_pincfg)
                oen_q <= wbyte[OEN_BIT];
        end
    end

    // wishbone answer one cycle after the strobe; unmapped reads return zero
    // a write lands on the taking edge, so the ack only confirms it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_q  <= bus_req;
            rdat_q <= bus_req ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // sequencer state and engaged flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q   <= ST_INTERNAL;
            src_ext_q <= 1'b0;  // [R3]
            engaged_q <= 1'b0;
            edges_q   <= 2'h0;
            int_run_q <= 1'b1;
        end
        else if (ce_i)
        begin
            state_q <= state_d;
            edges_q <= (state_q != ST_EDGES) ? 2'h0 : edges_q + {1'b0, ext_rise};  // [R13]
            if (engage_now)
            begin
                src_ext_q <= 1'b1;
                engaged_q <= 1'b1;  // [R9] [R13]
            end
            // internal oscillator stops one cycle after the engaged flag rises
            if (state_q == ST_EXTERNAL)
                int_run_q <= 1'b0;  // [R13]
            else
                int_run_q <= 1'b1;  // [R14]
            if (release_now)
            begin
                src_ext_q <= 1'b0;
                engaged_q <= 1'b0;  // [R9] [R14]
            end
        end
    end

    // internal oscillator model; no wait-mode input exists, so wait never stops it
    // a stopped oscillator parks low, so a restart begins with a full low half
    // shortening the half period mid-count ends that one half early
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            int_cnt_q <= 8'h00;
            int_lvl_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!int_run_q)
            begin
                int_cnt_q <= 8'h00;
                int_lvl_q <= 1'b0;
            end
            else if (int_done)
            begin
                int_cnt_q <= 8'h00;
                int_lvl_q <= ~int_lvl_q;  // [R5] [R11]
            end
            else
                int_cnt_q <= int_cnt_q + 8'h01;
        end
    end

    // bus clocks and pin drive
    // the double clock moves only on a quad rising edge, so it cannot glitch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            quad_q <= 1'b0;
            dbl_q  <= 1'b0;
            pin_q  <= '0;
        end
        else if (ce_i)
        begin
            quad_q <= src_lvl;  // [R5]
            if (quad_rise)
                dbl_q <= ~dbl_q;  // [R15]
            pin_q <= pin_d;  // [R1]
        end
    end

    // oscillator control outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clock_input_enable_o <= 1'b0;
            crystal_amp_enable_o <= AMP_OFF;
        end
        else if (ce_i)
        begin
            // the pin stays an input until the bus clock is back on the internal source
            clock_input_enable_o <= (sel_q != SEL_INTERNAL) | req_eff | src_ext_q;  // [R2] [R7] [R14]
            crystal_amp_enable_o <= amp_d;  // [R6]
        end
    end

    // every output comes straight from its flip-flop
    assign wb_o.ack              = ack_q;
    assign wb_o.dat              = rdat_q;
    assign quad_bus_clock_o      = quad_q;
    assign double_bus_clock_o    = dbl_q;
    assign internal_osc_run_o    = int_run_q;
    assign secondary_clock_pin_o = pin_q;

endmodule : ocs_clock_source

/* design/ocs_pkg.sv */
package ocs_pkg;

    // register byte addresses on the bus
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_TRIM    = 4'h4;
    localparam logic [3:0] ADDR_PINCFG  = 4'h8;

    // clock_source_control field positions
    localparam int SEL_HI  = 7;
    localparam int SEL_LO  = 6;
    localparam int IFS_HI  = 5;
    localparam int IFS_LO  = 4;
    localparam int XR_HI   = 3;
    localparam int XR_LO   = 2;
    localparam int REQ_BIT = 1;
    localparam int ENG_BIT = 0;
    localparam int OEN_BIT = 0;

    // clock source select encodings
    localparam logic [1:0] SEL_INTERNAL = 2'h0;
    localparam logic [1:0] SEL_EXT_CLK  = 2'h1;
    localparam logic [1:0] SEL_EXT_RC   = 2'h2;
    localparam logic [1:0] SEL_CRYSTAL  = 2'h3;

    // internal frequency select encodings
    localparam logic [1:0] IFS_4M0  = 2'h0;
    localparam logic [1:0] IFS_8M0  = 2'h1;
    localparam logic [1:0] IFS_12M8 = 2'h2;

    // crystal range encodings and amplifier one-hot enables
    localparam logic [1:0] XR_HIGH = 2'h0;
    localparam logic [1:0] XR_MID  = 2'h1;
    localparam logic [1:0] XR_LOW  = 2'h2;
    localparam logic [2:0] AMP_HIGH = 3'h1;
    localparam logic [2:0] AMP_MID  = 3'h2;
    localparam logic [2:0] AMP_LOW  = 3'h4;
    localparam logic [2:0] AMP_OFF  = 3'h0;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET    = 8'h80;
    localparam logic [7:0] TRIM_CENTRE   = 8'h80;

    // model of the internal oscillator: half periods in clk_i cycles, ratio 4.0 : 8.0 : 12.8
    localparam logic [7:0] HALF_4M0  = 8'h40;
    localparam logic [7:0] HALF_8M0  = 8'h20;
    localparam logic [7:0] HALF_12M8 = 8'h14;
    // one trim step is 1/512 of the untrimmed period, about 0.2 %
    localparam int TRIM_SHIFT = 9;

    // rising edges of the external clock seen before the switch
    localparam logic [1:0] EDGE_COUNT = 2'h2;

    typedef enum logic [2:0] {
        ST_INTERNAL = 3'b000,
        ST_EDGES    = 3'b001,
        ST_SWITCH   = 3'b010,
        ST_EXTERNAL = 3'b011,
        ST_BACK     = 3'b100
    } ocs_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ocs_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ocs_wb_rsp_t;

    typedef struct packed {
        logic out;
        logic oe;
    } ocs_pin_t;

endpackage : ocs_pkg

/* testbench/ocs_clock_source_bench.sv */
`timescale 1ns/10ps
module ocs_clock_source_bench
    import ocs_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        byp = 1'b0;
    logic        g_out = 1'b0;
    logic        g_oe = 1'b0;
    logic        ext_run = 1'b0;
    logic        pin, quad, dbl, run, cie, eng, qs;
    ocs_wb_req_t req = '0;
    ocs_wb_rsp_t rsp;
    ocs_pin_t    sec;
    logic [2:0]  amp, ea;
    logic [1:0]  ps;
    logic [7:0]  rdat;
    logic [7:0]  mdl [3];
    int          error_cnt = 0;
    int          checked = 0;
    int          hb, per;

    // 10 MHz clock
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    ocs_clock_source u_ocs_clock_source
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(1'b1),
        .wb_i(req),
        .wb_o(rsp),
        .clock_input_pin_i(pin),
        .monitor_bypass_i(byp),
        .gpio_out_i(g_out),
        .gpio_oe_i(g_oe),
        .secondary_clock_pin_o(sec),
        .quad_bus_clock_o(quad),
        .double_bus_clock_o(dbl),
        .internal_osc_run_o(run),
        .clock_input_enable_o(cie),
        .crystal_amp_enable_o(amp)
    );

    ocs_ext_osc u_ocs_ext_osc
    (
        .run_i(ext_run),
        .pin_o(pin)
    );

    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : cmp

    // periods carry a small tolerance for counter rounding
    task automatic near(input string nm, input int e, input int g);
        checked++;
        if (g < e - 2 || g > e + 2)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %0d got %0d", nm, e, g);
        end
    endtask : near

    // one classic cycle, entered just after a rising edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        req <= '{1'b1, 1'b1, w, a, s, {24'h0, d}};
        @(posedge clk_i);
        // no local limit: only the watchdog ends a wait for ack
        while (rsp.ack !== 1'b1)
            @(posedge clk_i);
        rdat = rsp.dat[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask : acc

    // write and keep the register model in step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 4'h1);
        if (a == ADDR_CONTROL)
            mdl[0] = d;
        if (a == ADDR_TRIM)
            mdl[1] = d;
        if (a == ADDR_PINCFG)
            mdl[2] = {7'h0, d[0]};
        if (mdl[0][SEL_HI:SEL_LO] == SEL_EXT_CLK)
            mdl[2] = 8'h00;
    endtask : wr

    task automatic rchk(input logic [3:0] a);
        logic [7:0] e;
        e = 8'h00;
        if (a == ADDR_CONTROL)
            e = {mdl[0][7:1], eng};
        if (a == ADDR_TRIM)
            e = mdl[1];
        if (a == ADDR_PINCFG)
            e = mdl[2];
        acc(1'b0, a, 8'h00, 4'hf);
        cmp("reg_read", e, rdat);
    endtask : rchk

    task automatic poll(input logic e);
        rdat[0] = ~e;
        for (int n = 0; n < 60 && rdat[0] !== e; n++)
            acc(1'b0, ADDR_CONTROL, 8'h00, 4'hf);
        eng = e;
        cmp("engaged", 8'(e), 8'(rdat[0]));
    endtask : poll

    // quad period; the first period after a change is skipped
    task automatic meas(output int p);
        logic q0;
        logic d0;
        int   r;
        r = 0;
        p = 0;
        q0 = quad;
        d0 = dbl;
        for (int n = 0; n < 2000 && r < 3; n++)
        begin
            @(posedge clk_i);
            if (quad === 1'b1 && q0 === 1'b0)
            begin
                r++;
                cmp("dbl_toggle", 8'(!d0), 8'(dbl));
            end
            if (r == 2)
                p++;
            q0 = quad;
            d0 = dbl;
        end
    endtask : meas

    // main sequence
    initial
    begin
        void'($urandom(93938));
        mdl[0] = CONTROL_RESET;
        mdl[1] = TRIM_RESET;
        mdl[2] = 8'h00;
        eng = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cmp("osc_run", 8'h01, 8'(run));
        rchk(ADDR_CONTROL);
        rchk(ADDR_TRIM);
        rchk(ADDR_PINCFG);
        rchk(4'hc);
        wr(ADDR_TRIM, 8'($urandom));
        acc(1'b1, ADDR_TRIM, 8'h5a, 4'he);
        rchk(ADDR_TRIM);
        wr(ADDR_CONTROL, 8'h01);
        rchk(ADDR_CONTROL);
        // every select and range code against pin and amplifier
        for (int i = 0; i < 16; i++)
        begin
            g_out <= 1'($urandom);
            g_oe <= 1'($urandom);
            wr(ADDR_CONTROL, {i[3:2], 2'($urandom), i[1:0], 2'b00});
            wr(ADDR_PINCFG, 8'h01);
            repeat (4) @(posedge clk_i);
            ps = i[3:2];
            ea = (ps == SEL_CRYSTAL && i[1:0] != 2'd3) ? AMP_HIGH << i[1:0] : AMP_OFF;
            cmp("amp", 8'(ea), 8'(amp));
            cmp("clk_in", 8'(ps != SEL_INTERNAL), 8'(cie));
            cmp("pin_oe", 8'(ps == SEL_EXT_CLK ? g_oe : 1'b1), 8'(sec.oe));
            // internal and RC with the enable set show the quad clock a cycle late
            qs = quad;
            @(posedge clk_i);
            cmp("pin_out", 8'(ps == SEL_CRYSTAL ? !pin : ps == SEL_EXT_CLK ? g_out : qs), 8'(sec.out));
            rchk(ADDR_PINCFG);
            rchk(ADDR_CONTROL);
        end
        // internal frequency and trim; the reserved code runs as 4.0 MHz
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_CONTROL, {2'b00, i[1:0], 4'h0});
            wr(ADDR_TRIM, i[2] ? 8'h00 : TRIM_CENTRE);
            hb = (i[1:0] == IFS_8M0) ? HALF_8M0 : (i[1:0] == IFS_12M8) ? HALF_12M8 : HALF_4M0;
            meas(per);
            near("period", 2 * (hb - (i[2] ? hb / 4 : 0)), per);
        end
        // request masked under bypass, then engagement and return
        wr(ADDR_CONTROL, {SEL_EXT_CLK, 6'h00});
        ext_run <= 1'b1;
        byp <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr(ADDR_CONTROL, {SEL_EXT_CLK, 6'h02});
        repeat (100) @(posedge clk_i);
        rchk(ADDR_CONTROL);
        cmp("osc_run", 8'h01, 8'(run));
        byp <= 1'b0;
        poll(1'b1);
        repeat (4) @(posedge clk_i);
        cmp("osc_run", 8'h00, 8'(run));
        meas(per);
        near("ext_period", 14, per);
        wr(ADDR_CONTROL, 8'h00);
        poll(1'b0);
        cmp("osc_run", 8'h01, 8'(run));
        ext_run <= 1'b0;
        meas(per);
        near("period", 2 * (HALF_4M0 - HALF_4M0 / 4), per);
        report_and_stop();
    end

    // watchdog: the sequence needs well under 30000 cycles
    initial
    begin
        #3000000;
        error_cnt++;
        report_and_stop();
    end
endmodule : ocs_clock_source_bench

/* testbench/ocs_clock_source_chk.sv */
`timescale 1ns/10ps
module ocs_clock_source_chk
    import ocs_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // bus
    input wire ocs_wb_req_t wb_i,
    input wire ocs_wb_rsp_t wb_o,
    // pin and clocks
    input wire ocs_pin_t    secondary_clock_pin_o,
    input wire logic        quad_bus_clock_o,
    input wire logic        double_bus_clock_o,
    input wire logic        internal_osc_run_o,
    input wire logic        clock_input_enable_o,
    input wire logic [2:0]  crystal_amp_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // bus handshake: a taken request, then ack for exactly one cycle
    sequence s_taken;
        ce_i && wb_i.cyc && wb_i.stb && !wb_o.ack;
    endsequence
    sequence s_ack;
        wb_o.ack ##1 !wb_o.ack;
    endsequence
    a_bus_ack: assert property (s_taken |=> s_ack)
        else $error("bus request not acked for one cycle");
    a_read_upper: assert property (wb_o.ack |-> wb_o.dat[31:8] == 24'h0)
        else $error("read data above lane 0 not zero");
    // state straight after reset
    a_reset_int: assert property ($fell(rst_i) |-> internal_osc_run_o && !clock_input_enable_o)
        else $error("internal oscillator not selected after reset");
    // double clock toggles once per quad rising edge
    a_dbl_rise: assert property ($rose(quad_bus_clock_o) |-> ##[0:1] $changed(double_bus_clock_o))
        else $error("double clock missed a quad rising edge");
    a_dbl_only: assert property ($changed(double_bus_clock_o) |-> quad_bus_clock_o)
        else $error("double clock moved while quad low");
    // every source is far slower than three cycles, so a shorter pulse is a glitch
    a_quad_glitch: assert property ($changed(quad_bus_clock_o) |=> $stable(quad_bus_clock_o) [*2])
        else $error("short pulse on quad clock");
    a_amp_onehot: assert property ($onehot0(crystal_amp_enable_o))
        else $error("several crystal amplifiers enabled");
    // pin and amplifier registers load on the same edge; the check waits a cycle all the same
    a_xtal_pin: assert property ((crystal_amp_enable_o != AMP_OFF) [*2] |-> secondary_clock_pin_o.oe)
        else $error("crystal mode without pin drive");
    a_run_stop: assert property ($fell(internal_osc_run_o) |-> $past(clock_input_enable_o, 2))
        else $error("internal oscillator stopped before external input");
endmodule : ocs_clock_source_chk

bind ocs_clock_source ocs_clock_source_chk u_ocs_clock_source_chk
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_i(wb_i),
    .wb_o(wb_o),
    .secondary_clock_pin_o(secondary_clock_pin_o),
    .quad_bus_clock_o(quad_bus_clock_o),
    .double_bus_clock_o(double_bus_clock_o),
    .internal_osc_run_o(internal_osc_run_o),
    .clock_input_enable_o(clock_input_enable_o),
    .crystal_amp_enable_o(crystal_amp_enable_o)
);

/* testbench/ocs_ext_osc.sv */
`timescale 1ns/10ps
// free-running external clock source on the input pin
module ocs_ext_osc
#(
    parameter int HALF_NS = 700
)
(
    // power
    input  wire logic run_i,
    // pin
    output logic      pin_o
);
    // an unpowered source holds the pin low, so no stale edge is seen
    initial
    begin
        pin_o = 1'b0;
        forever
        begin
            #(HALF_NS);
            pin_o = run_i & ~pin_o;
        end
    end
endmodule : ocs_ext_osc
